// File: design/flash_host_pkg.sv
// Purpose: Shared constants and types for the flash bank host controller.
// Assumes: 100 MHz clk; times below are in ns as named, cycles derived.
// Notes: Command codes and unlock addresses are named once here.
package flash_host_pkg;

  // Clock and cycle counter width
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 16;

  // Bus timing in ns
  localparam int GLITCH_REJECT_NS = 5;
  localparam int WE_LOW_NS = 40;
  localparam int WE_HIGH_NS = 30;
  localparam int READ_CYCLE_TIME_NS = 70;
  localparam int BUS_RECOVERY_TIME_NS = 1000;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_HIGH_TO_READ_NS = 1000;
  localparam int SYNC_STAGES = 2;

  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] WE_LOW_CYC = CNT_W'(
    (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WE_HIGH_CYC = CNT_W'(
    (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_WAIT_CYC = CNT_W'(
    (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [CNT_W-1:0] BUS_RECOVERY_CYC = CNT_W'(
    (BUS_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC = CNT_W'(
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_HIGH_CYC = CNT_W'(
    (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Pin widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // Command codes and addresses of the protected sequences
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 20'h002AA;
  localparam logic [ADDR_W-1:0] CHIP_ERASE_ADDR = 20'h05555;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_QUERY_ENTRY = 16'h0098;
  localparam logic [DATA_W-1:0] CMD_MODE_EXIT = 16'h00F0;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [1:0] CONFIRM_READS = 2'h2;

  // Software register map (byte offsets)
  localparam int REG_AW = 5;
  localparam logic [REG_AW-1:0] REG_CTRL = 5'h00;
  localparam logic [REG_AW-1:0] REG_ADDR = 5'h04;
  localparam logic [REG_AW-1:0] REG_WDATA = 5'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 5'h0C;
  localparam logic [REG_AW-1:0] REG_RDATA = 5'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 4;
  localparam int CTRL_WP_BIT = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_READY = 3;
  localparam int ST_REJECT = 4;

  // Orders that software can give
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_BLOCK_ERASE = 4'h4,
    OP_CHIP_ERASE = 4'h5,
    OP_ID_ENTRY = 4'h6,
    OP_QUERY_ENTRY = 4'h7,
    OP_MODE_EXIT = 4'h8,
    OP_HW_RESET = 4'h9
  } op_e;

  // Purpose of a read cycle
  typedef enum logic [1:0] {
    RD_PLAIN = 2'h0,
    RD_POLL = 2'h1,
    RD_VERIFY = 2'h2
  } rd_kind_e;

  // Sequencer states, Gray along write, poll, recover, reset
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WR_HIGH = 4'h1,
    S_WR_LOW = 4'h3,
    S_RD_ACC = 4'h2,
    S_RD_DONE = 4'h6,
    S_RECOVER = 4'h7,
    S_RST_LOW = 4'h5,
    S_RST_WAIT = 4'h4
  } state_e;

endpackage

// File: design/flash_pin_sync.sv
// Purpose: Two-stage synchroniser for levels arriving on flash pins.
// Assumes: Inputs change freely with respect to clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module flash_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] stage1;

  // Two flops in series, first feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      pin_sync <= '0;
    end else begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule

// File: design/flash_host_ctrl.sv
// Purpose: Host controller that drives a flash bank over its async pins.
// Assumes: Software orders through a plain register port on clk.
// Notes: Completion is judged from toggle, polarity poll and ready/busy.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Completion confirmed by two further matching reads
// - Wait bus recovery before trusting data
// - Protect pin stable through whole operation
// - Wait reset-high-to-read before first read
// - Unlock prefix before every program or erase
// - Query entry uses 98H at 555H
module flash_host_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Software register port
  input wire logic [flash_host_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash bank pins
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
  output logic flash_bank_select_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_wp_n,
  output logic flash_rst_n,
  input wire logic ready_busy_out_n
);

  typedef struct packed {
    flash_host_pkg::state_e st;
    logic [flash_host_pkg::CNT_W-1:0] cnt;
    logic [2:0] step;
    flash_host_pkg::op_e op;
    flash_host_pkg::rd_kind_e kind;
    logic [flash_host_pkg::ADDR_W-1:0] addr;
    logic [flash_host_pkg::DATA_W-1:0] wdata;
    logic [flash_host_pkg::DATA_W-1:0] rdata;
    logic rb_seen;
    logic [1:0] confirm;
    logic prev6;
    logic have_prev;
    logic wp;
    logic done;
    logic fail;
    logic rejected;
    logic we_n;
    logic oe_n;
    logic sel_n;
    logic rst_n;
    logic dq_oe_n;
    logic [flash_host_pkg::ADDR_W-1:0] pin_addr;
    logic [flash_host_pkg::DATA_W-1:0] pin_dq;
    logic [31:0] rd_out;
  } state_s;

  localparam state_s RESET_STATE = '{st: flash_host_pkg::S_IDLE,
    op: flash_host_pkg::OP_NONE, kind: flash_host_pkg::RD_PLAIN,
    we_n: 1'b1, oe_n: 1'b1, sel_n: 1'b1, rst_n: 1'b1, dq_oe_n: 1'b1,
    default: '0};

  state_s s;
  state_s n;
  logic [flash_host_pkg::DATA_W:0] sync_out;
  logic [flash_host_pkg::DATA_W-1:0] dq_sync;
  logic rb_sync;
  logic [2:0] seq_len;
  logic is_erase;
  logic poll_ok;
  logic tog_ok;
  logic complete;

  // Pin levels from outside pass two flops
  flash_pin_sync #(.W(flash_host_pkg::DATA_W + 1)) pin_sync_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({ready_busy_out_n, flash_dq_in}),
    .pin_sync(sync_out)
  );
  assign dq_sync = sync_out[flash_host_pkg::DATA_W-1:0];
  assign rb_sync = sync_out[flash_host_pkg::DATA_W];

  // Command word for one step of the protected sequence
  function automatic logic [flash_host_pkg::ADDR_W+flash_host_pkg::DATA_W-1:0]
      seq_word(input flash_host_pkg::op_e op, input logic [2:0] step,
               input logic [flash_host_pkg::ADDR_W-1:0] a,
               input logic [flash_host_pkg::DATA_W-1:0] d);
    logic [flash_host_pkg::DATA_W-1:0] cmd;
    cmd = flash_host_pkg::CMD_MODE_EXIT;
    case (op)
      flash_host_pkg::OP_PROGRAM: cmd = flash_host_pkg::CMD_PROGRAM;
      flash_host_pkg::OP_ID_ENTRY: cmd = flash_host_pkg::CMD_ID_ENTRY;
      flash_host_pkg::OP_QUERY_ENTRY: cmd = flash_host_pkg::CMD_QUERY_ENTRY;
      flash_host_pkg::OP_MODE_EXIT: cmd = flash_host_pkg::CMD_MODE_EXIT;
      default: cmd = flash_host_pkg::CMD_ERASE_SETUP;
    endcase
    case (step)
      3'h0: seq_word = {flash_host_pkg::UNLOCK_ADDR_A,
                        flash_host_pkg::UNLOCK_DATA_A};
      3'h1: seq_word = {flash_host_pkg::UNLOCK_ADDR_B,
                        flash_host_pkg::UNLOCK_DATA_B};
      3'h2: seq_word = {flash_host_pkg::UNLOCK_ADDR_A, cmd};
      3'h3: begin
        if (op == flash_host_pkg::OP_PROGRAM) begin
          seq_word = {a, d};
        end else begin
          seq_word = {flash_host_pkg::UNLOCK_ADDR_A,
                      flash_host_pkg::UNLOCK_DATA_A};
        end
      end
      3'h4: seq_word = {flash_host_pkg::UNLOCK_ADDR_B,
                        flash_host_pkg::UNLOCK_DATA_B};
      default: begin
        if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
          seq_word = {a, flash_host_pkg::CMD_SECTOR_ERASE};
        end else if (op == flash_host_pkg::OP_BLOCK_ERASE) begin
          seq_word = {a, flash_host_pkg::CMD_BLOCK_ERASE};
        end else begin
          seq_word = {flash_host_pkg::CHIP_ERASE_ADDR,
                      flash_host_pkg::CMD_CHIP_ERASE};
        end
      end
    endcase
  endfunction

  // Sequence length and completion tests for the current order
  always_comb begin
    is_erase = (s.op == flash_host_pkg::OP_SECTOR_ERASE) ||
               (s.op == flash_host_pkg::OP_BLOCK_ERASE) ||
               (s.op == flash_host_pkg::OP_CHIP_ERASE);
    if (s.op == flash_host_pkg::OP_PROGRAM) begin
      seq_len = 3'h4;
    end else if (is_erase) begin
      seq_len = 3'h6;
    end else begin
      seq_len = 3'h3;
    end
    poll_ok = is_erase ? s.rdata[flash_host_pkg::POLL_BIT]
      : (s.rdata[flash_host_pkg::POLL_BIT] ==
         s.wdata[flash_host_pkg::POLL_BIT]);
    tog_ok = s.have_prev &&
             (s.rdata[flash_host_pkg::TOGGLE_BIT] == s.prev6);
    complete = poll_ok && tog_ok && s.rb_seen;
  end

  // Next-state logic: register port and bus sequencer
  always_comb begin
    n = s;
    n.rd_out = '0;
    if (reg_rd) begin
      case (reg_addr)
        flash_host_pkg::REG_CTRL: n.rd_out = {23'h0, s.wp, 4'h0, s.op};
        flash_host_pkg::REG_ADDR: n.rd_out = {12'h0, s.addr};
        flash_host_pkg::REG_WDATA: n.rd_out = {16'h0, s.wdata};
        flash_host_pkg::REG_STATUS: n.rd_out = {27'h0, s.rejected, rb_sync,
          s.fail, s.done, s.st != flash_host_pkg::S_IDLE};
        flash_host_pkg::REG_RDATA: n.rd_out = {16'h0, s.rdata};
        default: n.rd_out = '0;
      endcase
    end
    case (s.st)
      flash_host_pkg::S_IDLE: begin
        if (reg_wr && reg_addr == flash_host_pkg::REG_ADDR) begin
          n.addr = reg_wdata[flash_host_pkg::ADDR_W-1:0];
        end
        if (reg_wr && reg_addr == flash_host_pkg::REG_WDATA) begin
          n.wdata = reg_wdata[flash_host_pkg::DATA_W-1:0];
        end
        if (reg_wr && reg_addr == flash_host_pkg::REG_CTRL) begin
          n.op = flash_host_pkg::op_e'(reg_wdata[flash_host_pkg::CTRL_OP_LSB
                 +: flash_host_pkg::CTRL_OP_W]);
          n.wp = reg_wdata[flash_host_pkg::CTRL_WP_BIT];
          n.cnt = '0;
          n.step = '0;
          n.confirm = '0;
          n.have_prev = 1'b0;
          n.rejected = 1'b0;
          case (n.op)
            flash_host_pkg::OP_NONE: n.st = flash_host_pkg::S_IDLE;
            flash_host_pkg::OP_READ: begin
              n.done = 1'b0;
              n.fail = 1'b0;
              n.st = flash_host_pkg::S_RD_ACC;
              n.kind = flash_host_pkg::RD_PLAIN;
              n.pin_addr = n.addr;
              n.sel_n = 1'b0;
              n.oe_n = 1'b0;
            end
            flash_host_pkg::OP_HW_RESET: begin
              n.done = 1'b0;
              n.fail = 1'b0;
              n.st = flash_host_pkg::S_RST_LOW;
              n.rst_n = 1'b0;
            end
            default: begin
              n.done = 1'b0;
              n.fail = 1'b0;
              n.st = flash_host_pkg::S_WR_HIGH;
            end
          endcase
        end
      end
      flash_host_pkg::S_WR_HIGH: begin
        n.cnt = s.cnt + 1'b1;
        if (s.step < seq_len) begin
          {n.pin_addr, n.pin_dq} = seq_word(s.op, s.step, s.addr, s.wdata);
          n.sel_n = 1'b0;
          n.dq_oe_n = 1'b0;
        end
        if (s.cnt == flash_host_pkg::WE_HIGH_CYC - 1'b1) begin
          n.cnt = '0;
          if (s.step < seq_len) begin
            n.we_n = 1'b0;
            n.st = flash_host_pkg::S_WR_LOW;
          end else if (is_erase ||
                       s.op == flash_host_pkg::OP_PROGRAM) begin
            n.dq_oe_n = 1'b1;
            n.oe_n = 1'b0;
            n.pin_addr = s.addr;
            n.kind = flash_host_pkg::RD_POLL;
            n.st = flash_host_pkg::S_RD_ACC;
          end else begin
            n.dq_oe_n = 1'b1;
            n.sel_n = 1'b1;
            n.done = 1'b1;
            n.st = flash_host_pkg::S_IDLE;
          end
        end
      end
      flash_host_pkg::S_WR_LOW: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == flash_host_pkg::WE_LOW_CYC - 1'b1) begin
          n.cnt = '0;
          n.we_n = 1'b1;
          n.step = s.step + 1'b1;
          n.st = flash_host_pkg::S_WR_HIGH;
        end
      end
      flash_host_pkg::S_RD_ACC: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == flash_host_pkg::READ_WAIT_CYC - 1'b1) begin
          n.cnt = '0;
          n.rdata = dq_sync;
          n.rb_seen = rb_sync;
          n.oe_n = 1'b1;
          n.sel_n = 1'b1;
          n.st = flash_host_pkg::S_RD_DONE;
        end
      end
      flash_host_pkg::S_RD_DONE: begin
        if (s.kind == flash_host_pkg::RD_POLL) begin
          n.prev6 = s.rdata[flash_host_pkg::TOGGLE_BIT];
          n.have_prev = 1'b1;
          n.confirm = complete ? s.confirm + 1'b1 : 2'h0;
          if (complete && s.confirm == flash_host_pkg::CONFIRM_READS) begin
            n.st = flash_host_pkg::S_RECOVER;
          end else begin
            n.sel_n = 1'b0;
            n.oe_n = 1'b0;
            n.st = flash_host_pkg::S_RD_ACC;
          end
        end else begin
          n.done = 1'b1;
          if (s.kind == flash_host_pkg::RD_VERIFY) begin
            n.fail = s.rdata != (is_erase ? flash_host_pkg::ERASED_WORD
                                          : s.wdata);
          end
          n.st = flash_host_pkg::S_IDLE;
        end
      end
      flash_host_pkg::S_RECOVER: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == flash_host_pkg::BUS_RECOVERY_CYC - 1'b1) begin
          n.cnt = '0;
          n.kind = flash_host_pkg::RD_VERIFY;
          n.sel_n = 1'b0;
          n.oe_n = 1'b0;
          n.st = flash_host_pkg::S_RD_ACC;
        end
      end
      flash_host_pkg::S_RST_LOW: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == flash_host_pkg::RESET_PULSE_CYC - 1'b1) begin
          n.cnt = '0;
          n.rst_n = 1'b1;
          n.st = flash_host_pkg::S_RST_WAIT;
        end
      end
      flash_host_pkg::S_RST_WAIT: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == flash_host_pkg::RESET_HIGH_CYC - 1'b1) begin
          n.cnt = '0;
          n.done = 1'b1;
          n.st = flash_host_pkg::S_IDLE;
        end
      end
      default: n = RESET_STATE;
    endcase
    // Orders while busy are dropped and flagged
    if (reg_wr && s.st != flash_host_pkg::S_IDLE) begin
      n.rejected = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= RESET_STATE;
    end else begin
      s <= n;
    end
  end

  // Pins and read data straight from flops
  assign reg_rdata = s.rd_out;
  assign flash_addr = s.pin_addr;
  assign flash_dq_out = s.pin_dq;
  assign flash_dq_oe_n = s.dq_oe_n;
  assign flash_bank_select_n = s.sel_n;
  assign flash_we_n = s.we_n;
  assign flash_oe_n = s.oe_n;
  assign flash_wp_n = s.wp;
  assign flash_rst_n = s.rst_n;

  a_we_oe_excl: assert property (@(posedge clk) disable iff (sys_rst)
    !(!flash_we_n && !flash_oe_n))
    else $error("write strobe low with output gate low");
  a_we_select: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_we_n |-> !flash_bank_select_n && !flash_dq_oe_n)
    else $error("write strobe without select or data drive");
  a_we_pulse_len: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flash_we_n) |-> (!flash_we_n)[*4] ##1 flash_we_n)
    else $error("write pulse length wrong");
  a_wp_stable: assert property (@(posedge clk) disable iff (sys_rst)
    s.st != flash_host_pkg::S_IDLE |=> $stable(flash_wp_n))
    else $error("protect pin moved during operation");
  a_rst_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flash_rst_n) |-> (!flash_rst_n)[*8])
    else $error("reset pulse too short");
  a_recover_wait: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(s.st == flash_host_pkg::S_RECOVER) |->
      (flash_oe_n && s.st == flash_host_pkg::S_RECOVER)[*8])
    else $error("data read before bus recovery");
  a_poll_after_seq: assert property (@(posedge clk) disable iff (sys_rst)
    s.st == flash_host_pkg::S_RD_ACC && s.kind == flash_host_pkg::RD_POLL
      |-> s.step == seq_len)
    else $error("poll before last write pulse");
  a_confirm_done: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(s.st == flash_host_pkg::S_RECOVER) |->
      $past(s.confirm) == flash_host_pkg::CONFIRM_READS)
    else $error("completion without two confirming reads");
  a_no_drive_read: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_oe_n |-> flash_dq_oe_n && flash_we_n)
    else $error("data bus driven during read");

endmodule

// File: tb/flash_dev_model.sv
// Purpose: Behavioural flash bank answering the host controller.
// Assumes: Ready/busy is pulled up outside; busy times are shortened.
// Notes: Released data lines show the inverse of the last word.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 4000,
  parameter int RST_MIN_NS = 500,
  parameter logic [15:0] MAKER = 16'h00A1, // Arbitrary value
  parameter logic [15:0] PART = 16'h0B2C, // Arbitrary value
  parameter logic [15:0] QUERY = 16'h0051
) (
  // Pins from the host
  input wire logic [19:0] addr,
  input wire logic [15:0] dq,
  input wire logic select_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic wp_n,
  input wire logic rst_n,
  // Pins to the host
  output wire logic [15:0] dq_dev,
  output wire ready_busy_out_n
);
  logic [15:0] mem [int];
  logic [15:0] word = 16'hFFFF;
  logic [15:0] pdata = 16'h0000;
  logic prog = 1'b0;
  logic tgl = 1'b0;
  int busy_ns = 0;
  int step = 0;
  int mode = 0;
  int resets = 0;
  realtime t_we = 0;
  realtime t_rst = 0;
  wire rd_en = !select_n && !oe_n && rst_n;
  wire busy = busy_ns > 0;
  // Outer 4 KWord of the first bank is guarded while the pin is low
  function automatic bit guarded(int a);
    return a < 'h1000 && wp_n !== 1'b1;
  endfunction
  // Internal operation timer
  always #10 begin
    if (busy_ns > 0) busy_ns -= 10;
  end
  // Erase sector, block or whole array; a bad last cycle is dropped
  task automatic erase(int a, logic [7:0] c);
    int sh;
    int q[$];
    sh = c == 8'h30 ? 10 : c == 8'h50 ? 15 : 20;
    if (c == 8'h10 ? a != 'h5555 : c != 8'h30 && c != 8'h50) return;
    if (c != 8'h10 && guarded(a)) return;
    foreach (mem[k]) if (k >> sh == a >> sh && !guarded(k)) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
    prog = 1'b0;
    busy_ns = ERASE_NS;
  endtask
  // Protected command sequences, decoded on the rising write edge
  task automatic decode(int a, logic [15:0] d);
    int nxt;
    nxt = 0; // Anything unexpected drops back to step 0; the read mode is kept
    case (step)
      0, 13: if (a == 'h555 && d[7:0] == 8'hAA) nxt = step ? 4 : 1;
      1, 4: if (a == 'h2AA && d[7:0] == 8'h55) nxt = step + 1;
      2: if (a == 'h555) begin
        nxt = d[7:0] == 8'hA0 ? 3 : d[7:0] == 8'h80 ? 13 : 0;
        if (d[7:0] == 8'h90) mode = 1;
        if (d[7:0] == 8'h98) mode = 2;
        if (d[7:0] == 8'hF0) mode = 0;
      end
      3: if (!guarded(a)) begin
        mem[a] = d;
        pdata = d;
        prog = 1'b1;
        busy_ns = PROG_NS;
      end
      5: erase(a, d[7:0]);
      default: nxt = 0;
    endcase
    step = nxt;
  endtask
  always @(negedge we_n) t_we = $realtime;
  // Only a selected, ungated, long enough pulse while idle is taken
  always @(posedge we_n) begin
    if (!select_n && oe_n && rst_n && !busy && $realtime - t_we >= 5.0)
      decode(int'(addr), dq);
  end
  // Status replaces data on each new read while an operation runs
  always @(posedge rd_en) begin
    #1; // Address pins update in the same step as the gate
    tgl = tgl ^ busy;
    word = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
    if (mode == 1 && addr < 20'h2) word = addr[0] ? PART : MAKER;
    if (mode == 2) word = QUERY;
    if (busy) word = {pdata[15:8], prog & !pdata[7], tgl, pdata[5:0]};
  end // Poll and toggle bits valid from launch
  assign dq_dev = rd_en ? word : ~word;
  assign ready_busy_out_n = busy && rd_en ? 1'b0 : 1'bz;
  always @(negedge rst_n) t_rst = $realtime;
  // A long enough reset pulse aborts work and restores array read
  always @(posedge rst_n) begin
    if ($realtime - t_rst >= RST_MIN_NS) begin
      busy_ns = 0;
      step = 0;
      mode = 0;
      resets++;
    end
  end
endmodule

// File: tb/tb_flash_write_status_protect.sv
// Purpose: Self-checking bench for the flash bank host controller.
// Assumes: A behavioural flash bank model sits on the pins.
// Notes: Identity codes handed to the model are arbitrary values.
`timescale 1ns/1ps
module tb_flash_write_status_protect;
  localparam logic [15:0] MAKER = 16'h00A1; // Arbitrary value
  localparam logic [15:0] PART = 16'h0B2C; // Arbitrary value
  localparam logic [15:0] QUERY = 16'h0051;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wp_rel = 1'b1;
  logic [31:0] reg_rdata;
  logic [19:0] fa;
  logic [15:0] dq_h, dq_d, dq;
  logic dq_oe_n, sel_n, we_n, oe_n, wp_n, rst_n;
  tri1 rb_n;
  int fails = 0;
  int checked = 0;
  // Shared data bus: host drives while its enable is low
  assign dq = dq_oe_n ? dq_d : dq_h;
  flash_host_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_out(dq_h),
    .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq), .flash_bank_select_n(sel_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_wp_n(wp_n),
    .flash_rst_n(rst_n), .ready_busy_out_n(rb_n));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .QUERY(QUERY)) u_dev (
    .addr(fa), .dq(dq), .select_n(sel_n), .we_n(we_n), .oe_n(oe_n),
    .wp_n(wp_n), .rst_n(rst_n), .dq_dev(dq_d), .ready_busy_out_n(rb_n));
  initial forever #5 clk = ~clk;
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [31:0] fl(logic [31:0] st);
    return {31'h0, st[flash_host_pkg::ST_FAIL]};
  endfunction
  // Load address and data, then order the operation
  task automatic start(logic [3:0] op, logic [19:0] a, logic [15:0] d);
    wr(flash_host_pkg::REG_ADDR, {12'h000, a});
    wr(flash_host_pkg::REG_WDATA, {16'h0000, d});
    wr(flash_host_pkg::REG_CTRL, {23'h000000, wp_rel, 4'h0, op});
  endtask
  // Poll status until done, within a bound
  task automatic wait_done(output logic [31:0] st);
    st = 32'h0;
    for (int n = 0; st[flash_host_pkg::ST_DONE] !== 1'b1; n++) begin
      if (n == 5000) begin
        chk("completion", 32'h1, 32'h0);
        final_report();
      end
      rd(flash_host_pkg::REG_STATUS, st);
    end
  endtask
  task automatic run_op(logic [3:0] op, logic [19:0] a, logic [15:0] d,
                        output logic [31:0] st);
    start(op, a, d);
    wait_done(st);
  endtask
  task automatic fread(logic [19:0] a, output logic [15:0] w);
    logic [31:0] r;
    run_op(flash_host_pkg::OP_READ, a, 16'h0000, r);
    rd(flash_host_pkg::REG_RDATA, r);
    w = r[15:0];
  endtask
  // Idle pins after reset; unmapped register reads zero
  task automatic t_idle;
    logic [31:0] r;
    chk("idle strobes", 32'h7, {29'h0, we_n, oe_n, sel_n});
    rd(5'h14, r);
    chk("unmapped read", 32'h0, r);
    rd(flash_host_pkg::REG_STATUS, r);
    chk("idle status", 32'h8, r);
  endtask
  // Program a word and read it back
  task automatic t_prog;
    logic [31:0] st;
    logic [15:0] w;
    run_op(flash_host_pkg::OP_PROGRAM, 20'h20000, 16'h5AC3, st);
    chk("program fail", 32'h0, fl(st));
    fread(20'h20000, w);
    chk("program data", 32'h5AC3, {16'h0, w});
  endtask
  // Each erase kind wipes a freshly programmed word
  task automatic t_erase;
    logic [31:0] st;
    logic [15:0] w;
    logic [3:0] ops [3];
    ops = '{flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_BLOCK_ERASE,
            flash_host_pkg::OP_CHIP_ERASE};
    foreach (ops[i]) begin
      run_op(flash_host_pkg::OP_PROGRAM, 20'h20400, 16'h1234, st);
      run_op(ops[i], 20'h20400, 16'h0000, st);
      chk("erase fail", 32'h0, fl(st));
      fread(20'h20400, w);
      chk("erased word", 32'hFFFF, {16'h0, w});
    end
  endtask
  // Guarded region refuses until the protect pin is released
  task automatic t_guard;
    logic [31:0] st;
    logic [15:0] w;
    for (int k = 0; k < 2; k++) begin
      wp_rel = k[0];
      run_op(flash_host_pkg::OP_PROGRAM, 20'h00010, 16'h00C5, st);
      chk("guarded fail", {31'h0, !k[0]}, fl(st));
      fread(20'h00010, w);
      chk("guarded word", k ? 32'h00C5 : 32'hFFFF, {16'h0, w});
    end
  endtask
  // Identification and query modes, each left by the exit order
  task automatic t_modes;
    logic [31:0] st;
    logic [15:0] w;
    run_op(flash_host_pkg::OP_ID_ENTRY, 20'h0, 16'h0, st);
    fread(20'h00000, w);
    chk("maker code", {16'h0, MAKER}, {16'h0, w});
    fread(20'h00001, w);
    chk("part code", {16'h0, PART}, {16'h0, w});
    run_op(flash_host_pkg::OP_MODE_EXIT, 20'h0, 16'h0, st);
    fread(20'h00001, w);
    chk("array after exit", 32'hFFFF, {16'h0, w});
    run_op(flash_host_pkg::OP_QUERY_ENTRY, 20'h0, 16'h0, st);
    fread(20'h00010, w);
    chk("query word", {16'h0, QUERY}, {16'h0, w});
    run_op(flash_host_pkg::OP_MODE_EXIT, 20'h0, 16'h0, st);
    fread(20'h00010, w);
    chk("array after query", 32'h00C5, {16'h0, w});
  endtask
  // Order during an operation is refused; hardware reset afterwards
  task automatic t_busy;
    logic [31:0] st;
    logic [15:0] w;
    start(flash_host_pkg::OP_PROGRAM, 20'h30000, 16'h0077);
    wr(flash_host_pkg::REG_CTRL, 32'h00000101);
    rd(flash_host_pkg::REG_STATUS, st);
    chk("rejected", 32'h1, {31'h0, st[flash_host_pkg::ST_REJECT]});
    wait_done(st);
    chk("busy program fail", 32'h0, fl(st));
    run_op(flash_host_pkg::OP_HW_RESET, 20'h0, 16'h0, st);
    chk("reject clear", 32'h0, {31'h0, st[flash_host_pkg::ST_REJECT]});
    chk("device resets", 32'h1, 32'(u_dev.resets));
    fread(20'h30000, w);
    chk("after reset", 32'h0077, {16'h0, w});
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_idle();
    t_prog();
    t_erase();
    t_guard();
    t_modes();
    t_busy();
    final_report();
  end
endmodule
